// file: rtl/ssis_agen.sv
`timescale 1ns/10ps
module ssis_agen (
  ssis_agen_if.agen a
);
  import ssis_pkg::*;

  always_comb begin
    a.addr     = a.ptr;
    a.ptr_next = a.ptr;
    a.sp_next  = a.sp;
    case (a.op)
      OP_POSTINC_WR: begin
        a.ptr_next = a.ptr + 16'h0001;
      end
      OP_PREDEC_WR: begin
        a.addr     = a.ptr - 16'h0001;
        a.ptr_next = a.ptr - 16'h0001;
      end
      OP_OFFSET_WR: begin
        a.addr = a.ptr + {10'h000, a.disp};
      end
      OP_ABS_WR: begin
        a.addr = a.abs_addr;
      end
      OP_CODE_RD_INC: begin
        a.ptr_next = a.ptr + 16'h0001;
      end
      OP_PUSH: begin
        a.addr    = a.sp;
        a.sp_next = a.sp - 16'h0001;
      end
      OP_POP: begin
        // Stack grows down, top byte sits just above the pointer
        a.addr    = a.sp + 16'h0001;
        a.sp_next = a.sp + 16'h0001;
      end
      default: begin
        a.addr = a.ptr;
      end
    endcase
  end

endmodule : ssis_agen

// file: rtl/ssis_agen_if.sv
`timescale 1ns/10ps
interface ssis_agen_if;
  import ssis_pkg::*;
  ssis_op_t    op;
  logic [15:0] ptr;
  logic [15:0] sp;
  logic [5:0]  disp;
  logic [15:0] abs_addr;
  logic [15:0] addr;
  logic [15:0] ptr_next;
  logic [15:0] sp_next;

  modport core (output op, ptr, sp, disp, abs_addr, input addr, ptr_next, sp_next);
  modport agen (input op, ptr, sp, disp, abs_addr, output addr, ptr_next, sp_next);
endinterface : ssis_agen_if

// file: rtl/ssis_core.sv
// Functional notes
// - Post-increment write stores source at pointer, then pointer plus one; 2 cycles.
// - Pre-decrement write lowers pointer first, stores at new address; 2 cycles.
// - Offset write stores at pointer plus displacement, pointer unchanged; 2 cycles.
// - Absolute write stores at address from instruction word; 2 cycles.
// - Code read loads byte at pointer into register or zero; optional increment; 3 cycles.
// - Code write sends work one:work zero word to program memory at pointer.
// - Push places source register on stack in 2 cycles.
// - Pop returns top stack byte into destination register in 2 cycles.
// - Watchdog restart takes one cycle and pulses the watchdog.
// - Port B pin three is pulled low while the low-power oscillator stops.
// - Watchdog enable or any other demand starts the low-power oscillator.
`timescale 1ns/10ps
module ssis_core #(
  parameter logic [15:0] SP_INIT = ssis_pkg::SP_RESET
) (
  input  wire logic               mclk,
  input  wire logic               srst,
  input  wire logic               instr_valid,
  output      logic               instr_ready,
  input  wire ssis_pkg::ssis_op_t instr_op,
  input  wire logic [4:0]         instr_reg,
  input  wire logic [5:0]         instr_disp,
  input  wire logic [15:0]        instr_addr,
  input  wire logic [5:0]         instr_io,
  output      logic               instr_done,
  output      logic [15:0]        dm_addr,
  output      logic [7:0]         dm_wdata,
  output      logic               dm_we,
  output      logic               dm_re,
  input  wire logic [7:0]         dm_rdata,
  output      logic [15:0]        pm_addr,
  output      logic [15:0]        pm_wdata,
  output      logic               pm_we,
  output      logic               pm_re,
  input  wire logic [7:0]         pm_rdata,
  output      logic [5:0]         io_addr,
  output      logic [7:0]         io_wdata,
  output      logic               io_we,
  output      logic               io_re,
  input  wire logic [7:0]         io_rdata,
  input  wire logic               rf_wr_en,
  input  wire logic [4:0]         rf_wr_addr,
  input  wire logic [7:0]         rf_wr_data,
  input  wire logic [4:0]         rf_rd_addr,
  output      logic [7:0]         rf_rd_data,
  output      logic [15:0]        stack_ptr,
  output      logic               watchdog_restart,
  input  wire logic               wdt_enable,
  input  wire logic               osc_demand,
  output      logic               low_power_oscillator_run,
  input  wire logic               port_b_pin_three_in,
  output      logic               port_b_pin_three_out,
  output      logic               port_b_pin_three_oe,
  output      logic               port_b_pin_three_data
);
  import ssis_pkg::*;

  ssis_state_t state_q;
  ssis_op_t    op_q;
  logic [4:0]  dest_q;
  logic [7:0]  rf_q [32];
  logic [15:0] sp_q;
  logic [15:0] dm_addr_q, pm_addr_q, pm_wdata_q;
  logic [7:0]  dm_wdata_q, io_wdata_q, rf_rd_q, pin_data_q;
  logic [5:0]  io_addr_q;
  logic        dm_we_q, dm_re_q, pm_we_q, pm_re_q, io_we_q, io_re_q;
  logic        wdog_q, done_q, osc_run_q;
  logic        accept;
  logic [15:0] ptr;
  logic [7:0]  src_val;
  logic [15:0] code_word;
  logic        ptr_upd;
  int unsigned cycles;

  ssis_agen_if ag ();

  ssis_agen u_agen (
    .a (ag.agen)
  );

  assign ptr       = {rf_q[PTR_HI_IDX], rf_q[PTR_LO_IDX]};
  assign src_val   = rf_q[instr_reg];
  assign code_word = {rf_q[WORK_ONE_IDX], rf_q[WORK_ZERO_IDX]};
  assign accept    = instr_valid && instr_ready;

  assign ag.op       = instr_op;
  assign ag.ptr      = ptr;
  assign ag.sp       = sp_q;
  assign ag.disp     = instr_disp;
  assign ag.abs_addr = instr_addr;

  assign ptr_upd = (instr_op == OP_POSTINC_WR) || (instr_op == OP_PREDEC_WR) ||
                   (instr_op == OP_CODE_RD_INC);

  always_comb begin
    case (instr_op)
      OP_CODE_RD_R0, OP_CODE_RD, OP_CODE_RD_INC: cycles = CYC_CODE_RD;
      OP_CODE_WR:                               cycles = CYC_CODE_WR;
      OP_PUSH, OP_POP:                          cycles = CYC_STACK;
      OP_IO_IN, OP_IO_OUT, OP_WDOG, OP_NONE:    cycles = CYC_SINGLE;
      default:                                  cycles = CYC_DATA_WR;
    endcase
  end

  assign instr_ready = (state_q == ST_IDLE);

  // Sequencer: one-cycle ops never leave idle
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      op_q    <= OP_NONE;
      dest_q  <= 5'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            op_q    <= instr_op;
            dest_q  <= (instr_op == OP_CODE_RD_R0) ? WORK_ZERO_IDX : instr_reg;
            state_q <= (cycles > CYC_SINGLE) ? ST_MEM : ST_IDLE;
          end
        end
        ST_MEM:  state_q <= (op_q inside {OP_CODE_RD_R0, OP_CODE_RD, OP_CODE_RD_INC}) ?
                            ST_WAIT : ST_IDLE;
        ST_WAIT: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (accept && cycles == CYC_SINGLE) || (state_q == ST_MEM && op_q != OP_CODE_RD_R0
                && op_q != OP_CODE_RD && op_q != OP_CODE_RD_INC) || (state_q == ST_WAIT);
    end
  end
  assign instr_done = done_q;

  // Data memory strobes, issued in the cycle after acceptance
  always_ff @(posedge mclk) begin
    if (srst) begin
      dm_we_q    <= 1'b0;
      dm_re_q    <= 1'b0;
      dm_addr_q  <= 16'h0000;
      dm_wdata_q <= 8'h00;
    end else begin
      dm_we_q <= accept && (instr_op inside {OP_IND_WR, OP_POSTINC_WR, OP_PREDEC_WR,
                 OP_OFFSET_WR, OP_ABS_WR, OP_PUSH});
      dm_re_q <= accept && (instr_op == OP_POP);
      if (accept) begin
        dm_addr_q  <= ag.addr;
        dm_wdata_q <= src_val;
      end
    end
  end

  // Program memory: pointer is a byte address, data comes back one cycle after the read
  always_ff @(posedge mclk) begin
    if (srst) begin
      pm_we_q    <= 1'b0;
      pm_re_q    <= 1'b0;
      pm_addr_q  <= 16'h0000;
      pm_wdata_q <= 16'h0000;
    end else begin
      pm_we_q <= accept && (instr_op == OP_CODE_WR);
      pm_re_q <= accept && (instr_op inside {OP_CODE_RD_R0, OP_CODE_RD, OP_CODE_RD_INC});
      if (accept) begin
        pm_addr_q  <= ptr;
        pm_wdata_q <= code_word;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      io_we_q    <= 1'b0;
      io_re_q    <= 1'b0;
      io_addr_q  <= 6'h00;
      io_wdata_q <= 8'h00;
      wdog_q     <= 1'b0;
    end else begin
      io_we_q <= accept && (instr_op == OP_IO_OUT);
      io_re_q <= accept && (instr_op == OP_IO_IN);
      wdog_q  <= accept && (instr_op == OP_WDOG);
      if (accept) begin
        io_addr_q  <= instr_io;
        io_wdata_q <= src_val;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sp_q <= SP_INIT;
    end else if (accept && (instr_op == OP_PUSH || instr_op == OP_POP)) begin
      sp_q <= ag.sp_next;
    end
  end

  // Register file; the sequenced writes override an external write in the same cycle.
  // No status flags live here, so none of these ops can alter them.
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < 32; i++) begin
        rf_q[i] <= REG_RESET;
      end
    end else begin
      if (rf_wr_en) begin
        rf_q[rf_wr_addr] <= rf_wr_data;
      end
      if (accept && ptr_upd) begin
        rf_q[PTR_LO_IDX] <= ag.ptr_next[7:0];
        rf_q[PTR_HI_IDX] <= ag.ptr_next[15:8];
      end
      if (state_q == ST_MEM && op_q == OP_POP) begin
        rf_q[dest_q] <= dm_rdata;
      end
      if (state_q == ST_WAIT) begin
        rf_q[dest_q] <= pm_rdata;
      end
      if (io_re_q) begin
        rf_q[dest_q] <= io_rdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rf_rd_q <= 8'h00;
    end else begin
      rf_rd_q <= rf_q[rf_rd_addr];
    end
  end

  // Oscillator start and pin pull-down; the pin reads low while the oscillator stops
  always_ff @(posedge mclk) begin
    if (srst) begin
      osc_run_q  <= 1'b0;
      pin_data_q <= 8'h00;
    end else begin
      osc_run_q  <= wdt_enable || osc_demand;
      pin_data_q <= {7'h00, osc_run_q && port_b_pin_three_in};
    end
  end

  assign port_b_pin_three_out     = 1'b0;
  assign port_b_pin_three_oe      = !osc_run_q;
  assign port_b_pin_three_data    = pin_data_q[0];
  assign low_power_oscillator_run = osc_run_q;

  assign dm_addr          = dm_addr_q;
  assign dm_wdata         = dm_wdata_q;
  assign dm_we            = dm_we_q;
  assign dm_re            = dm_re_q;
  assign pm_addr          = pm_addr_q;
  assign pm_wdata         = pm_wdata_q;
  assign pm_we            = pm_we_q;
  assign pm_re            = pm_re_q;
  assign io_addr          = io_addr_q;
  assign io_wdata         = io_wdata_q;
  assign io_we            = io_we_q;
  assign io_re            = io_re_q;
  assign rf_rd_data       = rf_rd_q;
  assign stack_ptr        = sp_q;
  assign watchdog_restart = wdog_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  postinc_ptr_a: assert property (accept && instr_op == OP_POSTINC_WR |=>
    dm_we && dm_addr == $past(ptr) && ptr == $past(ptr) + 16'h0001 ##1 instr_ready)
    else $error("post-increment write wrong");
  predec_ptr_a: assert property (accept && instr_op == OP_PREDEC_WR |=>
    dm_we && dm_addr == $past(ptr) - 16'h0001 && ptr == dm_addr)
    else $error("pre-decrement write wrong");
  offset_addr_a: assert property (accept && instr_op == OP_OFFSET_WR |=> !instr_ready &&
    dm_we && dm_addr == $past(ptr) + {10'h000, $past(instr_disp)} && ptr == $past(ptr))
    else $error("offset write wrong");
  abs_addr_a: assert property (accept && instr_op == OP_ABS_WR |=>
    dm_we && dm_addr == $past(instr_addr) && dm_wdata == $past(src_val))
    else $error("absolute write wrong");
  code_rd_len_a: assert property (accept &&
    instr_op inside {OP_CODE_RD_R0, OP_CODE_RD, OP_CODE_RD_INC} |=>
    pm_re && !instr_ready ##1 !instr_ready ##1 instr_ready && instr_done)
    else $error("code read not three cycles");
  code_wr_word_a: assert property (accept && instr_op == OP_CODE_WR |=>
    pm_we && pm_wdata == $past(code_word) && pm_addr == $past(ptr))
    else $error("code write word wrong");
  push_sp_a: assert property (accept && instr_op == OP_PUSH |=>
    dm_we && stack_ptr == $past(stack_ptr) - 16'h0001 ##1 instr_ready)
    else $error("push wrong");
  pop_sp_a: assert property (accept && instr_op == OP_POP |=> !instr_ready &&
    dm_re && dm_addr == stack_ptr && stack_ptr == $past(stack_ptr) + 16'h0001 ##1 instr_ready)
    else $error("pop wrong");
  wdog_pulse_a: assert property (accept && instr_op == OP_WDOG |->
    ##1 watchdog_restart && instr_done) else $error("watchdog restart missing");
  pin_pull_a: assert property (!low_power_oscillator_run |->
    port_b_pin_three_oe && !port_b_pin_three_out ##1 !port_b_pin_three_data)
    else $error("pin not pulled low");
  osc_start_a: assert property ((wdt_enable || osc_demand) |=> low_power_oscillator_run)
    else $error("oscillator not started");
  io_out_a: assert property (accept && instr_op == OP_IO_OUT |=>
    io_we && io_wdata == $past(src_val) && io_addr == $past(instr_io))
    else $error("port out wrong");

  push_seen_c: cover property (accept && instr_op == OP_PUSH ##2 accept && instr_op == OP_POP);
  code_rd_inc_c: cover property (accept && instr_op == OP_CODE_RD_INC);
  pin_pull_c: cover property (low_power_oscillator_run ##1 !low_power_oscillator_run);

endmodule : ssis_core

// file: rtl/ssis_pkg.sv
package ssis_pkg;

  typedef enum logic [3:0] {
    OP_NONE        = 4'h0,
    OP_IND_WR      = 4'h1,
    OP_POSTINC_WR  = 4'h2,
    OP_PREDEC_WR   = 4'h3,
    OP_OFFSET_WR   = 4'h4,
    OP_ABS_WR      = 4'h5,
    OP_CODE_RD_R0  = 4'h6,
    OP_CODE_RD     = 4'h7,
    OP_CODE_RD_INC = 4'h8,
    OP_CODE_WR     = 4'h9,
    OP_PUSH        = 4'hA,
    OP_POP         = 4'hB,
    OP_IO_IN       = 4'hC,
    OP_IO_OUT      = 4'hD,
    OP_WDOG        = 4'hE
  } ssis_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MEM  = 3'b010,
    ST_WAIT = 3'b100
  } ssis_state_t;

  localparam int unsigned CYC_DATA_WR = 2;
  localparam int unsigned CYC_CODE_RD = 3;
  localparam int unsigned CYC_CODE_WR = 2;
  localparam int unsigned CYC_STACK   = 2;
  localparam int unsigned CYC_SINGLE  = 1;

  localparam logic [4:0]  WORK_ZERO_IDX = 5'h00;
  localparam logic [4:0]  WORK_ONE_IDX  = 5'h01;
  localparam logic [4:0]  PTR_LO_IDX    = 5'h1E;
  localparam logic [4:0]  PTR_HI_IDX    = 5'h1F;
  localparam logic [15:0] SP_RESET      = 16'h03FF;
  localparam logic [7:0]  REG_RESET     = 8'h00;

endpackage : ssis_pkg

// file: verification/ssis_mem_model.sv
`timescale 1ns/10ps
module ssis_mem_model (
  input  wire logic        mclk,
  input  wire logic [15:0] dm_addr,
  input  wire logic [7:0]  dm_wdata,
  input  wire logic        dm_we,
  input  wire logic        dm_re,
  output      logic [7:0]  dm_rdata,
  input  wire logic [15:0] pm_addr,
  input  wire logic        pm_re,
  output      logic [7:0]  pm_rdata,
  input  wire logic [5:0]  io_addr,
  input  wire logic        io_re,
  output      logic [7:0]  io_rdata
);
  logic [7:0] dmem [0:1023];
  logic [7:0] pm_q = 8'h00;
  logic       pm_vld_q = 1'b0;
  // Off-cycle data is inverted so a late or early sample cannot pass by luck
  assign dm_rdata = dm_re ? dmem[dm_addr[9:0]] : ~dmem[dm_addr[9:0]];
  assign io_rdata = io_re ? ({2'h0, io_addr} ^ 8'hC3) : ~({2'h0, io_addr} ^ 8'hC3);
  assign pm_rdata = pm_vld_q ? pm_q : ~pm_q;
  initial begin
    for (int i = 0; i < 1024; i++) dmem[i] = 8'h00;
  end
  // Code memory byte is its address low byte xor 5A, answered one cycle late
  always @(posedge mclk) begin
    pm_vld_q <= pm_re;
    pm_q     <= pm_addr[7:0] ^ 8'h5A;
    if (dm_we) dmem[dm_addr[9:0]] <= dm_wdata;
  end
endmodule : ssis_mem_model

// file: verification/store_and_stack_instr_subset_bench.sv
`timescale 1ns/10ps
module store_and_stack_instr_subset_bench;
  import ssis_pkg::*;
  logic        mclk = 1'b0, srst = 1'b1, instr_valid = 1'b0, rf_wr_en = 1'b0;
  logic        wdt_enable = 1'b0, osc_demand = 1'b0, port_b_pin_three_in = 1'b0;
  ssis_op_t    instr_op = OP_NONE;
  logic [4:0]  instr_reg = 5'h00, rf_wr_addr = 5'h00, rf_rd_addr = 5'h00;
  logic [5:0]  instr_disp = 6'h00, instr_io = 6'h00, io_addr, io_a;
  logic [15:0] instr_addr = 16'h0000, dm_addr, pm_addr, pm_wdata, stack_ptr, pm_a, pm_w, p;
  logic [7:0]  rf_wr_data = 8'h00, dm_wdata, dm_rdata, pm_rdata, io_wdata, io_rdata;
  logic [7:0]  rf_rd_data, io_w, v;
  logic        instr_ready, instr_done, dm_we, dm_re, pm_we, pm_re, io_we, io_re;
  logic        watchdog_restart, low_power_oscillator_run;
  logic        port_b_pin_three_out, port_b_pin_three_oe, port_b_pin_three_data;
  int          miscompares = 0, num_checks = 0, dm_wr_n = 0, pm_wr_n = 0, wd_n = 0;

  always #5 mclk = ~mclk;

  ssis_core u_dut (
    .mclk, .srst, .instr_valid, .instr_ready, .instr_op, .instr_reg, .instr_disp, .instr_addr,
    .instr_io, .instr_done, .dm_addr, .dm_wdata, .dm_we, .dm_re, .dm_rdata, .pm_addr,
    .pm_wdata, .pm_we, .pm_re, .pm_rdata, .io_addr, .io_wdata, .io_we, .io_re, .io_rdata,
    .rf_wr_en, .rf_wr_addr, .rf_wr_data, .rf_rd_addr, .rf_rd_data, .stack_ptr,
    .watchdog_restart, .wdt_enable, .osc_demand, .low_power_oscillator_run,
    .port_b_pin_three_in, .port_b_pin_three_out, .port_b_pin_three_oe, .port_b_pin_three_data
  );
  ssis_mem_model u_mem (
    .mclk, .dm_addr, .dm_wdata, .dm_we, .dm_re, .dm_rdata, .pm_addr, .pm_re, .pm_rdata,
    .io_addr, .io_re, .io_rdata
  );

  // Strobes are counted at the edge that closes their cycle
  always @(posedge mclk) begin
    if (dm_we) dm_wr_n++;
    if (watchdog_restart) wd_n++;
    if (pm_we) begin
      pm_wr_n++;
      pm_a = pm_addr;
      pm_w = pm_wdata;
    end
    if (io_we) begin
      io_a = io_addr;
      io_w = io_wdata;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task automatic set_reg(input logic [4:0] a, input logic [7:0] d);
    rf_wr_en = 1'b1;
    rf_wr_addr = a;
    rf_wr_data = d;
    @(negedge mclk);
    rf_wr_en = 1'b0;
    // Let one edge pass so back-to-back writes never re-raise the enable in one step
    @(negedge mclk);
  endtask : set_reg

  // Register read port has one cycle of latency
  task automatic get_reg(input logic [4:0] a, output logic [7:0] d);
    rf_rd_addr = a;
    @(negedge mclk);
    d = rf_rd_data;
  endtask : get_reg

  task automatic set_ptr(input logic [15:0] q);
    set_reg(PTR_LO_IDX, q[7:0]);
    set_reg(PTR_HI_IDX, q[15:8]);
  endtask : set_ptr

  task automatic get_ptr(output logic [15:0] q);
    logic [7:0] lo;
    logic [7:0] hi;
    get_reg(PTR_LO_IDX, lo);
    get_reg(PTR_HI_IDX, hi);
    q = {hi, lo};
  endtask : get_ptr

  // Offers one instruction and measures cycles until the sequencer is free again
  task automatic run_op(input ssis_op_t op, input logic [4:0] r, input int unsigned n);
    int k;
    instr_op = op;
    instr_reg = r;
    instr_valid = 1'b1;
    k = 0;
    while (instr_ready !== 1'b1 && k < 10) begin
      @(negedge mclk);
      k++;
    end
    @(negedge mclk);
    instr_valid = 1'b0;
    k = 1;
    while (instr_ready !== 1'b1 && k < 10) begin
      @(negedge mclk);
      k++;
    end
    check(16'(k), 16'(n));
    check(16'(instr_done), 16'h1);
    @(negedge mclk);
  endtask : run_op

  task automatic t_reset;
    check(stack_ptr, SP_RESET);
    check(16'(low_power_oscillator_run), 16'h0);
    check(16'(port_b_pin_three_oe), 16'h1);
    $display("reset test finished");
  endtask : t_reset

  task automatic t_data_wr;
    int n;
    n = dm_wr_n;
    set_ptr(16'h01FF);
    set_reg(5'h05, 8'h3C);
    run_op(OP_POSTINC_WR, 5'h05, CYC_DATA_WR);
    get_ptr(p);
    check(16'(u_mem.dmem[10'h1FF]), 16'h3C);
    check(p, 16'h0200);
    set_reg(5'h05, 8'hC3);
    run_op(OP_PREDEC_WR, 5'h05, CYC_DATA_WR);
    get_ptr(p);
    check(16'(u_mem.dmem[10'h1FF]), 16'hC3);
    check(p, 16'h01FF);
    instr_disp = 6'h3F;
    set_reg(5'h05, 8'h5E);
    run_op(OP_OFFSET_WR, 5'h05, CYC_DATA_WR);
    get_ptr(p);
    check(16'(u_mem.dmem[10'h23E]), 16'h5E);
    check(p, 16'h01FF);
    instr_addr = 16'h0345;
    run_op(OP_ABS_WR, 5'h05, CYC_DATA_WR);
    check(16'(u_mem.dmem[10'h345]), 16'h5E);
    run_op(OP_IND_WR, 5'h05, CYC_DATA_WR);
    get_ptr(p);
    check(16'(u_mem.dmem[10'h1FF]), 16'h5E);
    check(p, 16'h01FF);
    check(16'(dm_wr_n - n), 16'h5);
    $display("data write test finished");
  endtask : t_data_wr

  task automatic t_code_mem;
    int n;
    set_ptr(16'h0123);
    run_op(OP_CODE_RD_R0, 5'h09, CYC_CODE_RD);
    get_reg(WORK_ZERO_IDX, v);
    check(16'(v), 16'h79);
    run_op(OP_CODE_RD, 5'h07, CYC_CODE_RD);
    get_reg(5'h07, v);
    check(16'(v), 16'h79);
    run_op(OP_CODE_RD_INC, 5'h08, CYC_CODE_RD);
    get_reg(5'h08, v);
    check(16'(v), 16'h79);
    get_ptr(p);
    check(p, 16'h0124);
    set_reg(WORK_ONE_IDX, 8'hBE);
    set_reg(WORK_ZERO_IDX, 8'hEF);
    n = pm_wr_n;
    run_op(OP_CODE_WR, 5'h00, CYC_CODE_WR);
    check(16'(pm_wr_n - n), 16'h1);
    check(pm_a, 16'h0124);
    check(pm_w, 16'hBEEF);
    $display("code memory test finished");
  endtask : t_code_mem

  // Two pushes then two pops: bytes must return in reverse order
  task automatic t_stack;
    set_reg(5'h09, 8'h77);
    set_reg(5'h0A, 8'h88);
    run_op(OP_PUSH, 5'h09, CYC_STACK);
    check(16'(u_mem.dmem[10'h3FF]), 16'h77);
    check(stack_ptr, 16'h03FE);
    run_op(OP_PUSH, 5'h0A, CYC_STACK);
    check(16'(u_mem.dmem[10'h3FE]), 16'h88);
    run_op(OP_POP, 5'h0B, CYC_STACK);
    run_op(OP_POP, 5'h0C, CYC_STACK);
    check(stack_ptr, SP_RESET);
    get_reg(5'h0B, v);
    check(16'(v), 16'h88);
    get_reg(5'h0C, v);
    check(16'(v), 16'h77);
    $display("stack test finished");
  endtask : t_stack

  task automatic t_single;
    int n;
    n = wd_n;
    run_op(OP_WDOG, 5'h00, CYC_SINGLE);
    check(16'(wd_n - n), 16'h1);
    instr_io = 6'h2A;
    run_op(OP_IO_OUT, 5'h09, CYC_SINGLE);
    check(16'(io_a), 16'h2A);
    check(16'(io_w), 16'h77);
    instr_io = 6'h15;
    run_op(OP_IO_IN, 5'h0D, CYC_SINGLE);
    get_reg(5'h0D, v);
    check(16'(v), 16'hD6);
    $display("single cycle test finished");
  endtask : t_single

  task automatic t_osc;
    port_b_pin_three_in = 1'b1;
    wdt_enable = 1'b1;
    @(negedge mclk);
    check(16'(low_power_oscillator_run), 16'h1);
    repeat (2) @(negedge mclk);
    check(16'(port_b_pin_three_oe), 16'h0);
    check(16'(port_b_pin_three_data), 16'h1);
    wdt_enable = 1'b0;
    osc_demand = 1'b1;
    repeat (2) @(negedge mclk);
    check(16'(low_power_oscillator_run), 16'h1);
    osc_demand = 1'b0;
    repeat (3) @(negedge mclk);
    check(16'(low_power_oscillator_run), 16'h0);
    check(16'(port_b_pin_three_oe), 16'h1);
    check(16'(port_b_pin_three_out), 16'h0);
    check(16'(port_b_pin_three_data), 16'h0);
    $display("oscillator test finished");
  endtask : t_osc

  initial begin
    #20000;
    miscompares++;
    end_of_test();
  end

  initial begin
    repeat (12) @(negedge mclk);
    srst = 1'b0;
    @(negedge mclk);
    t_reset();
    t_data_wr();
    t_code_mem();
    t_stack();
    t_single();
    t_osc();
    end_of_test();
  end
endmodule : store_and_stack_instr_subset_bench
